/* lpmc_pkg.sv */
// low-power mode controller: shared constants, register map and carrier types
// assumes one 10 MHz core clock and a single AHB-Lite master
package lpmc_pkg;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CLK  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;

	localparam logic [1:0] LOW_POWER_MODE_SELECT_STOP0   = 2'h0;
	localparam logic [1:0] LOW_POWER_MODE_SELECT_STOP1   = 2'h1;
	localparam logic [1:0] LOW_POWER_MODE_SELECT_STOP2   = 2'h2;
	localparam logic [1:0] LOW_POWER_MODE_SELECT_STANDBY = 2'h3;
	localparam int         LOW_POWER_MODE_SELECT_SHUT_BIT = 2;

	// multi-speed oscillator range code meaning 4 MHz
	localparam logic [3:0] MSI_RANGE_4MHZ = 4'h6;

	localparam int WK_PVD         = 0;
	localparam int WK_RF_IRQ      = 1;
	localparam int WK_RF_BUSY     = 2;
	localparam int WK_PIN         = 3;
	localparam int WK_RTC_TAMPER_UNIT    = 4;
	localparam int WK_XTAL_FAIL   = 5;
	localparam int WK_RESET_PIN   = 6;
	localparam int WK_WATCHDOG    = 7;
	localparam int NUM_WAKE       = 8;
	localparam logic [NUM_WAKE-1:0] SHUT_WAKE_MASK = 8'h58;
	localparam int NUM_FAST_REQ   = 4;

	typedef enum logic [3:0] {
		MODE_RUN, MODE_LPRUN, MODE_SLEEP, MODE_LPSLEEP, MODE_STOP0,
		MODE_STOP1, MODE_STOP2, MODE_STANDBY, MODE_SHUTDOWN
	} lpmc_mode_t;

	typedef enum logic [1:0] {SYSCLK_MSI, SYSCLK_FAST, SYSCLK_XTAL32, SYSCLK_PLL} lpmc_sysclk_t;

	// control register image, low bits of word at ADDR_CTRL
	typedef struct packed {
		logic       range2;
		logic       io_release;
		logic       wake_clk_sel;
		logic       sram2_keep;
		logic       lp_reg_sel;
		logic       deep_sleep;
		logic [2:0] low_power_mode_select;
	} lpmc_ctrl_t;

	typedef struct packed {
		logic cpu;
		logic fast_osc;
		logic multi_speed_osc;
		logic slow_int;
		logic slow_xtal;
		logic periph;
	} lpmc_clk_en_t;

	typedef struct packed {
		logic main_reg;
		logic lp_reg;
		logic radio_reg;
		logic sram2_keep;
		logic stop2_keep;
		logic vcore_range1;
	} lpmc_pwr_t;

	typedef struct packed {
		logic analog;
		logic schmitt_en;
		logic debug_pull;
		logic reset_pullup;
		logic pull_hold;
		logic pull_discard;
	} lpmc_io_t;

	typedef struct packed {
		lpmc_mode_t          mode;
		logic                wake_on_event;
		lpmc_ctrl_t          ctrl;
		lpmc_sysclk_t        sysclk;
		logic [3:0]          msi_range;
		logic [NUM_WAKE-1:0] wk_s1;
		logic [NUM_WAKE-1:0] wk_s2;
		logic                pin_prev;
		logic                rdeep_s1;
		logic                rdeep_s2;
		logic                pull_discard;
		logic                ph_wr;
		logic [ADDR_W-1:0]   ph_addr;
		logic [31:0]         rdata;
	} lpmc_state_t;

	localparam lpmc_state_t ST_RST = '{mode: MODE_RUN, sysclk: SYSCLK_MSI,
		msi_range: MSI_RANGE_4MHZ, default: '0};

endpackage

/* lpmc_top.sv */
// low-power mode controller: mode sequencer, clock and regulator gating, radio limits
// assumes cpu request strobes and event lines come from logic on CORE_CLK_IN;
// ASYNC_WAKE_IN and RADIO_DEEP_SLEEP_IN come from pins or other clocks
module lpmc_top
	import lpmc_pkg::*;
(
	input  wire logic                    CORE_CLK_IN,
	input  wire logic                    RSTN_IN,
	input  wire logic                    HSEL_IN,
	input  wire logic [31:0]             HADDR_IN,
	input  wire logic [1:0]              HTRANS_IN,
	input  wire logic                    HWRITE_IN,
	input  wire logic [2:0]              HSIZE_IN,
	input  wire logic [31:0]             HWDATA_IN,
	input  wire logic                    HREADY_IN,
	output logic      [31:0]             HRDATA_OUT,
	output logic                         HREADYOUT_OUT,
	output logic                         HRESP_OUT,
	input  wire logic                    WFI_IN,
	input  wire logic                    WFE_IN,
	input  wire logic                    ISR_RETURN_IN,
	input  wire logic                    IRQ_ANY_IN,
	input  wire logic                    WAKE_EVENT_IN,
	input  wire logic                    EVENT_LINE_WAKE_IN,
	input  wire logic                    PERIPH_WAKE_IN,
	input  wire logic [NUM_FAST_REQ-1:0] FAST_OSC_REQ_IN,
	input  wire logic [NUM_WAKE-1:0]     ASYNC_WAKE_IN,
	input  wire logic                    RADIO_DEEP_SLEEP_IN,
	input  wire logic                    INT_RESET_SRC_IN,
	output lpmc_mode_t                   MODE_OUT,
	output lpmc_sysclk_t                 SYSCLK_SEL_OUT,
	output logic      [3:0]              MSI_RANGE_OUT,
	output lpmc_clk_en_t                 CLK_EN_OUT,
	output logic      [NUM_FAST_REQ-1:0] FAST_OSC_ROUTE_OUT,
	output lpmc_pwr_t                    PWR_OUT,
	output logic                         RADIO_BLOCK_DEEP_OUT,
	output logic                         RADIO_FORCE_DEEP_OUT,
	output lpmc_io_t                     IO_OUT
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_stop(input lpmc_mode_t m);
		return (m == MODE_STOP0) || (m == MODE_STOP1) || (m == MODE_STOP2);
	endfunction

	function automatic logic is_cpu_off(input lpmc_mode_t m);
		return (m != MODE_RUN) && (m != MODE_LPRUN);
	endfunction

	function automatic logic is_lp_side(input lpmc_mode_t m);
		return (m == MODE_LPRUN) || (m == MODE_LPSLEEP) || (m == MODE_STOP1) ||
			(m == MODE_STOP2) || (m == MODE_STANDBY);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs decoded from the mode, the control register and a few direct inputs

	lpmc_state_t         st_r;
	lpmc_state_t         st_nxt;
	logic                sleep_req;
	logic [NUM_WAKE-1:0] wake_vec;
	logic                rdeep;

	assign rdeep     = st_r.rdeep_s2;
	assign sleep_req = WFI_IN | WFE_IN | ISR_RETURN_IN;

	always_comb begin
		wake_vec         = st_r.wk_s2;
		// wake pin counts on either edge, not on level
		wake_vec[WK_PIN] = st_r.wk_s2[WK_PIN] ^ st_r.pin_prev;
	end

	always_comb begin
		CLK_EN_OUT.cpu       = !is_cpu_off(st_r.mode);
		CLK_EN_OUT.multi_speed_osc       = !is_stop(st_r.mode) && st_r.mode != MODE_STANDBY &&
			st_r.mode != MODE_SHUTDOWN;
		CLK_EN_OUT.periph    = CLK_EN_OUT.multi_speed_osc;
		// fast oscillator runs in stop only while a peripheral asks for it
		CLK_EN_OUT.fast_osc  = is_stop(st_r.mode) ? |FAST_OSC_REQ_IN : CLK_EN_OUT.multi_speed_osc;
		CLK_EN_OUT.slow_int  = st_r.mode != MODE_SHUTDOWN;
		CLK_EN_OUT.slow_xtal = 1'b1;
		FAST_OSC_ROUTE_OUT   = CLK_EN_OUT.fast_osc ? FAST_OSC_REQ_IN : '0;

		PWR_OUT.main_reg   = st_r.mode == MODE_RUN || st_r.mode == MODE_SLEEP ||
			st_r.mode == MODE_STOP0;
		PWR_OUT.lp_reg     = st_r.mode == MODE_STANDBY ? st_r.ctrl.sram2_keep :
			st_r.mode != MODE_SHUTDOWN;
		PWR_OUT.sram2_keep = st_r.mode == MODE_STANDBY ? st_r.ctrl.sram2_keep :
			st_r.mode != MODE_SHUTDOWN;
		PWR_OUT.stop2_keep = st_r.mode != MODE_STANDBY && st_r.mode != MODE_SHUTDOWN;
		PWR_OUT.vcore_range1 = !st_r.ctrl.range2;
		if (st_r.mode == MODE_SHUTDOWN) begin
			PWR_OUT.radio_reg = 1'b0;
		end else if (is_lp_side(st_r.mode)) begin
			PWR_OUT.radio_reg = !rdeep;
		end else begin
			PWR_OUT.radio_reg = 1'b1;
		end
		RADIO_FORCE_DEEP_OUT = st_r.mode == MODE_SHUTDOWN;
		RADIO_BLOCK_DEEP_OUT = st_r.mode == MODE_RUN || st_r.mode == MODE_SLEEP ||
			st_r.mode == MODE_STOP0;

		IO_OUT.analog       = !st_r.ctrl.io_release;
		IO_OUT.schmitt_en   = st_r.ctrl.io_release;
		IO_OUT.debug_pull   = 1'b1;
		IO_OUT.reset_pullup = !INT_RESET_SRC_IN;
		IO_OUT.pull_hold    = st_r.mode == MODE_SHUTDOWN;
		IO_OUT.pull_discard = st_r.pull_discard;
	end

	assign MODE_OUT       = st_r.mode;
	assign SYSCLK_SEL_OUT = st_r.sysclk;
	assign MSI_RANGE_OUT  = st_r.msi_range;
	assign HRDATA_OUT     = st_r.rdata;
	assign HREADYOUT_OUT  = 1'b1;
	assign HRESP_OUT      = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt              = st_r;
		st_nxt.wk_s1        = ASYNC_WAKE_IN;
		st_nxt.wk_s2        = st_r.wk_s1;
		st_nxt.pin_prev     = st_r.wk_s2[WK_PIN];
		st_nxt.rdeep_s1     = RADIO_DEEP_SLEEP_IN;
		st_nxt.rdeep_s2     = st_r.rdeep_s1;
		st_nxt.pull_discard = 1'b0;
		st_nxt.ph_wr        = 1'b0;

		// address phase; zero wait states, so read data is ready for the data phase
		if (HSEL_IN && HREADY_IN && HTRANS_IN[1]) begin
			st_nxt.ph_wr   = HWRITE_IN;
			st_nxt.ph_addr = HADDR_IN[ADDR_W-1:0];
			if (!HWRITE_IN) begin
				unique case (HADDR_IN[ADDR_W-1:0])
					ADDR_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
					ADDR_CLK:  st_nxt.rdata = 32'({st_r.msi_range, 2'h0, st_r.sysclk});
					ADDR_STAT: st_nxt.rdata = 32'({rdeep, PWR_OUT, st_r.mode});
					default:   st_nxt.rdata = 32'h00000000;
				endcase
			end
		end

		// data phase write; hardware mode changes below take precedence
		if (st_r.ph_wr) begin
			if (st_r.ph_addr == ADDR_CTRL) begin
				st_nxt.ctrl = lpmc_ctrl_t'(HWDATA_IN[$bits(lpmc_ctrl_t)-1:0]);
			end else if (st_r.ph_addr == ADDR_CLK) begin
				st_nxt.sysclk    = lpmc_sysclk_t'(HWDATA_IN[1:0]);
				st_nxt.msi_range = HWDATA_IN[7:4];
			end
		end

		unique case (st_r.mode)
			MODE_RUN, MODE_LPRUN: begin
				if (sleep_req) begin
					// mode bits are taken as they stand at the request
					st_nxt.wake_on_event = WFE_IN && !WFI_IN && !ISR_RETURN_IN;
					if (!st_r.ctrl.deep_sleep) begin
						st_nxt.mode = st_r.mode == MODE_LPRUN ? MODE_LPSLEEP : MODE_SLEEP;
					end else if (st_r.ctrl.low_power_mode_select[LOW_POWER_MODE_SELECT_SHUT_BIT]) begin
						st_nxt.mode = MODE_SHUTDOWN;
					end else begin
						unique case (st_r.ctrl.low_power_mode_select[1:0])
							LOW_POWER_MODE_SELECT_STOP0:   st_nxt.mode = MODE_STOP0;
							LOW_POWER_MODE_SELECT_STOP1:   st_nxt.mode = MODE_STOP1;
							LOW_POWER_MODE_SELECT_STOP2:   st_nxt.mode = MODE_STOP2;
							LOW_POWER_MODE_SELECT_STANDBY: st_nxt.mode = MODE_STANDBY;
						endcase
					end
				end else if (st_r.mode == MODE_RUN && st_r.ctrl.lp_reg_sel) begin
					st_nxt.mode = MODE_LPRUN;
				end else if (st_r.mode == MODE_LPRUN && !st_r.ctrl.lp_reg_sel) begin
					st_nxt.mode = MODE_RUN;
				end
			end
			MODE_SLEEP, MODE_LPSLEEP: begin
				// system clock selection is untouched, so wake resumes on it
				if (st_r.wake_on_event ? WAKE_EVENT_IN : IRQ_ANY_IN) begin
					st_nxt.mode = st_r.mode == MODE_LPSLEEP ? MODE_LPRUN : MODE_RUN;
				end
			end
			MODE_STOP0, MODE_STOP1, MODE_STOP2: begin
				if (EVENT_LINE_WAKE_IN || PERIPH_WAKE_IN) begin
					st_nxt.mode   = st_r.ctrl.lp_reg_sel ? MODE_LPRUN : MODE_RUN;
					st_nxt.sysclk = st_r.ctrl.wake_clk_sel ? SYSCLK_FAST : SYSCLK_MSI;
				end
			end
			MODE_STANDBY: begin
				if (|wake_vec) begin
					st_nxt.mode           = MODE_RUN;
					st_nxt.sysclk         = SYSCLK_MSI;
					st_nxt.msi_range      = MSI_RANGE_4MHZ;
					st_nxt.ctrl.lp_reg_sel = 1'b0;
				end
			end
			MODE_SHUTDOWN: begin
				if (|(wake_vec & SHUT_WAKE_MASK)) begin
					st_nxt.mode            = MODE_RUN;
					st_nxt.sysclk          = SYSCLK_MSI;
					st_nxt.msi_range       = MSI_RANGE_4MHZ;
					st_nxt.ctrl.lp_reg_sel = 1'b0;
					st_nxt.pull_discard    = 1'b1;
				end
			end
			default: st_nxt.mode = MODE_RUN;
		endcase
	end

	always_ff @(posedge CORE_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_cpu_clk_gate: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_SLEEP) |-> (!CLK_EN_OUT.cpu && CLK_EN_OUT.multi_speed_osc && CLK_EN_OUT.periph))
		else $error("sleep must gate only the cpu clock");

	a_sleep_irq_wake: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_SLEEP && !st_r.wake_on_event && IRQ_ANY_IN) |=>
		(st_r.mode == MODE_RUN && $stable(st_r.sysclk)))
		else $error("interrupt did not end sleep on same clock");

	a_lprun_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_RUN && st_r.ctrl.lp_reg_sel && !sleep_req) |=>
		(st_r.mode == MODE_LPRUN && !PWR_OUT.main_reg && PWR_OUT.lp_reg))
		else $error("low-power run not entered");

	a_stop0_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_RUN && sleep_req && st_r.ctrl.deep_sleep &&
		st_r.ctrl.low_power_mode_select == 3'h0) |=> (st_r.mode == MODE_STOP0 && PWR_OUT.main_reg &&
		PWR_OUT.lp_reg))
		else $error("stop 0 entry wrong");

	a_stop_wake_clk: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(is_stop(st_r.mode) && EVENT_LINE_WAKE_IN) |=>
		(st_r.sysclk == ($past(st_r.ctrl.wake_clk_sel) ? SYSCLK_FAST : SYSCLK_MSI)) &&
		$stable(st_r.msi_range))
		else $error("stop wake clock wrong");

	a_standby_regs: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_STANDBY) |-> (!PWR_OUT.main_reg &&
		PWR_OUT.lp_reg == st_r.ctrl.sram2_keep && !CLK_EN_OUT.fast_osc))
		else $error("standby regulators wrong");

	a_shut_radio: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_SHUTDOWN) |-> (RADIO_FORCE_DEEP_OUT && !PWR_OUT.radio_reg &&
		!CLK_EN_OUT.slow_int))
		else $error("radio not held in deep-sleep");

	a_radio_block: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_RUN || st_r.mode == MODE_STOP0) |-> RADIO_BLOCK_DEEP_OUT)
		else $error("radio deep-sleep not blocked");

	a_fast_route: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		is_stop(st_r.mode) |-> (FAST_OSC_ROUTE_OUT == FAST_OSC_REQ_IN &&
		CLK_EN_OUT.fast_osc == |FAST_OSC_REQ_IN))
		else $error("fast oscillator routing wrong");

	a_shut_discard: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_SHUTDOWN && |(wake_vec & SHUT_WAKE_MASK)) |=>
		(IO_OUT.pull_discard && st_r.mode == MODE_RUN) ##1 !IO_OUT.pull_discard)
		else $error("shutdown exit did not discard pulls");

	a_io_analog: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		$rose(rst_n_r) |-> (IO_OUT.analog && !IO_OUT.schmitt_en && PWR_OUT.vcore_range1))
		else $error("ios not analog after reset");

	a_lpsleep_regs: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_LPSLEEP) |-> (!PWR_OUT.main_reg && PWR_OUT.lp_reg && !CLK_EN_OUT.cpu))
		else $error("low-power sleep regulators wrong");

	a_stop1_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(!is_cpu_off(st_r.mode) && sleep_req && st_r.ctrl.deep_sleep &&
		st_r.ctrl.low_power_mode_select == {1'b0, LOW_POWER_MODE_SELECT_STOP1}) |=> (st_r.mode == MODE_STOP1))
		else $error("stop 1 entry wrong");

	a_stop2_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(!is_cpu_off(st_r.mode) && sleep_req && st_r.ctrl.deep_sleep &&
		st_r.ctrl.low_power_mode_select == {1'b0, LOW_POWER_MODE_SELECT_STOP2}) |=> (st_r.mode == MODE_STOP2 && PWR_OUT.stop2_keep))
		else $error("stop 2 entry wrong");

	a_stop_clocks: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		is_stop(st_r.mode) |-> (!CLK_EN_OUT.cpu && !CLK_EN_OUT.multi_speed_osc && !CLK_EN_OUT.periph &&
		CLK_EN_OUT.slow_int && CLK_EN_OUT.slow_xtal))
		else $error("stop clocks wrong");

	a_standby_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(!is_cpu_off(st_r.mode) && sleep_req && st_r.ctrl.deep_sleep &&
		st_r.ctrl.low_power_mode_select == {1'b0, LOW_POWER_MODE_SELECT_STANDBY}) |=> (st_r.mode == MODE_STANDBY && !PWR_OUT.main_reg))
		else $error("standby entry wrong");

	a_standby_wake: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_STANDBY && |wake_vec) |=> (st_r.mode == MODE_RUN &&
		st_r.sysclk == SYSCLK_MSI && st_r.msi_range == MSI_RANGE_4MHZ))
		else $error("standby wake clock wrong");

	a_shut_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(!is_cpu_off(st_r.mode) && sleep_req && st_r.ctrl.deep_sleep &&
		st_r.ctrl.low_power_mode_select[LOW_POWER_MODE_SELECT_SHUT_BIT]) |=> (st_r.mode == MODE_SHUTDOWN && !PWR_OUT.lp_reg))
		else $error("shutdown entry wrong");

	a_shut_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_SHUTDOWN && !(|(wake_vec & SHUT_WAKE_MASK))) |=>
		(st_r.mode == MODE_SHUTDOWN))
		else $error("shutdown left without a listed source");

	a_radio_reg_off: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		((st_r.mode == MODE_STOP1 || st_r.mode == MODE_STOP2 || st_r.mode == MODE_STANDBY) &&
		rdeep) |-> !PWR_OUT.radio_reg)
		else $error("radio regulator left on");

	a_pin_pullup: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		INT_RESET_SRC_IN |-> !IO_OUT.reset_pullup)
		else $error("reset pin pull-up left on");

	a_sleep_default: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(!is_cpu_off(st_r.mode) && sleep_req && !st_r.ctrl.deep_sleep) |=>
		(st_r.mode == MODE_SLEEP || st_r.mode == MODE_LPSLEEP))
		else $error("request without deep sleep not taken as sleep");

	a_event_wake: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n_r)
		(st_r.mode == MODE_SLEEP && st_r.wake_on_event && !WAKE_EVENT_IN) |=>
		(st_r.mode == MODE_SLEEP))
		else $error("event sleep left without an event");

endmodule

/* lpmc_partner.sv */
// partner model: the cpu's sleep strobes and the radio's deep-sleep state
// assumes the controller's core clock; the bench calls its tasks by name
module lpmc_partner (
	input  wire logic clk_in,
	input  wire logic block_deep_in,
	input  wire logic force_deep_in,
	output logic      wfi_out,
	output logic      wfe_out,
	output logic      isr_ret_out,
	output logic      radio_deep_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic want_deep = 1'b0;

	initial begin
		wfi_out = 1'b0;
		wfe_out = 1'b0;
		isr_ret_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// radio may drop to deep-sleep only when not blocked, and is held there when forced
	assign radio_deep_out = force_deep_in | (want_deep & ~block_deep_in);

	// kind: 0 wait_for_interrupt, 1 wait_for_event, 2 isr return, 3 both waits
	task automatic strobe(input logic [1:0] kind);
		@(posedge clk_in);
		wfi_out     <= (kind == 2'h0) || (kind == 2'h3);
		wfe_out     <= kind[0];
		isr_ret_out <= (kind == 2'h2);
		@(posedge clk_in);
		wfi_out     <= 1'b0;
		wfe_out     <= 1'b0;
		isr_ret_out <= 1'b0;
	endtask

	task automatic radio_sleep(input logic v);
		@(posedge clk_in);
		want_deep <= v;
	endtask
endmodule

/* test_low_power_mode_controller.sv */
// bench for the low-power mode controller: bus tasks, mode sequences, wake paths
// assumes one 10 MHz clock; bus answers are awaited, never assumed
module test_low_power_mode_controller;
	import lpmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic                clk = 1'b0;
	logic                rstn, hsel, hwrite, irq, evt, ev_line, pwake, int_rst;
	logic                hreadyout, hresp, wait_for_interrupt, wait_for_event, isr_ret, r_deep, blk, frc;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [31:0]         haddr, hwdata, hrdata;
	logic [3:0]          fast_req, msi_range, route;
	logic [NUM_WAKE-1:0] awake;
	lpmc_mode_t          mode;
	lpmc_sysclk_t        sysclk;
	lpmc_clk_en_t        ck;
	lpmc_pwr_t           pwr;
	lpmc_io_t            io;
	int                  mismatches = 0;
	int                  tests_run = 0;
	int                  discards = 0;

	always #50 clk = ~clk;
	always @(posedge clk) if (io.pull_discard === 1'b1) discards++;

	lpmc_top DUT (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
		.HRESP_OUT(hresp), .WFI_IN(wait_for_interrupt), .WFE_IN(wait_for_event), .ISR_RETURN_IN(isr_ret),
		.IRQ_ANY_IN(irq), .WAKE_EVENT_IN(evt), .EVENT_LINE_WAKE_IN(ev_line),
		.PERIPH_WAKE_IN(pwake), .FAST_OSC_REQ_IN(fast_req), .ASYNC_WAKE_IN(awake),
		.RADIO_DEEP_SLEEP_IN(r_deep), .INT_RESET_SRC_IN(int_rst), .MODE_OUT(mode),
		.SYSCLK_SEL_OUT(sysclk), .MSI_RANGE_OUT(msi_range), .CLK_EN_OUT(ck),
		.FAST_OSC_ROUTE_OUT(route), .PWR_OUT(pwr), .RADIO_BLOCK_DEEP_OUT(blk),
		.RADIO_FORCE_DEEP_OUT(frc), .IO_OUT(io));

	lpmc_partner u_cpu (.clk_in(clk), .block_deep_in(blk), .force_deep_in(frc),
		.wfi_out(wait_for_interrupt), .wfe_out(wait_for_event), .isr_ret_out(isr_ret), .radio_deep_out(r_deep));

	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// slave may stretch either phase, so both waits are open-ended up to a cap
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		haddr  <= {24'h000000, a};
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 50) begin n++; @(posedge clk); end
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 100) begin n++; @(posedge clk); end
		q = hrdata;
		chk("bus answer", 32'h2, {30'h0, hreadyout, hresp});
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_mode(input lpmc_mode_t m, input string what);
		int n;
		n = 0;
		hold(1);
		while (mode !== m && n < 12) begin n++; hold(1); end
		chk(what, 32'(m), 32'(mode));
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 100);
		mismatches++;
		$display("watchdog expired");
		close_out();
	end

	initial begin
		logic [31:0] q;
		{hsel, hwrite, irq, evt, ev_line, pwake, int_rst, rstn} = 8'h00;
		{htrans, hsize, haddr, hwdata, fast_req, awake} = '0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		hold(3);
		chk("mode", 32'(MODE_RUN), 32'(mode));
		chk("core range", 32'h1, 32'(pwr.vcore_range1));
		chk("regulators", 32'h3, {30'h0, pwr.main_reg, pwr.lp_reg});
		chk("io state", 32'h5, {29'h0, io.analog, io.schmitt_en, io.debug_pull});
		chk("radio limits", 32'h2, {30'h0, blk, frc});
		@(posedge clk);
		int_rst <= 1'b1;
		#1;
		chk("pin pull-up", 32'h0, 32'(io.reset_pullup));
		@(posedge clk);
		int_rst <= 1'b0;
		#1;
		chk("pin pull-up", 32'h1, 32'(io.reset_pullup));
		ahb(1'b0, 8'h0C, 32'h0, q);
		chk("unmapped", 32'h0, q);
		ahb(1'b1, ADDR_CTRL, 32'h00000180, q);
		ahb(1'b0, ADDR_CTRL, 32'h0, q);
		chk("ctrl readback", 32'h00000180, q);
		chk("io released", 32'h2, {29'h0, io.analog, io.schmitt_en, pwr.vcore_range1});
		@(posedge clk);
		rstn <= 1'b0;
		hold(2);
		chk("io in reset", 32'h5, {29'h0, io.analog, io.schmitt_en, pwr.vcore_range1});
		@(posedge clk);
		rstn <= 1'b1;
		hold(3);
		chk("io after reset", 32'h5, {29'h0, io.analog, io.schmitt_en, pwr.vcore_range1});
		chk("mode after reset", 32'(MODE_RUN), 32'(mode));
		$display("test reset done");

		// deep_sleep clear: low_power_mode_select must not matter, every request is plain sleep
		ahb(1'b1, ADDR_CTRL, 32'h00000004, q);
		for (int k = 0; k < 4; k++) begin
			u_cpu.strobe(k[1:0]);
			wait_mode(MODE_SLEEP, "sleep entry");
			chk("sleep clocks", 32'h3, {29'h0, ck.cpu, ck.multi_speed_osc, ck.periph});
			chk("sleep regs", 32'h3, {30'h0, pwr.main_reg, pwr.lp_reg});
			chk("sleep clock", 32'(SYSCLK_MSI), 32'(sysclk));
			if (k == 1) begin
				@(posedge clk);
				irq <= 1'b1;
				hold(5);
				chk("event sleep", 32'(MODE_SLEEP), 32'(mode));
				@(posedge clk);
				evt <= 1'b1;
			end else begin
				@(posedge clk);
				irq <= 1'b1;
			end
			wait_mode(MODE_RUN, "sleep wake");
			@(posedge clk);
			irq <= 1'b0;
			evt <= 1'b0;
		end
		$display("test sleep done");

		ahb(1'b1, ADDR_CTRL, 32'h00000010, q);
		wait_mode(MODE_LPRUN, "lp run");
		chk("lp run regs", 32'h1, {30'h0, pwr.main_reg, pwr.lp_reg});
		ahb(1'b0, ADDR_STAT, 32'h0, q);
		chk("status mode", 32'(MODE_LPRUN), {28'h0, q[3:0]});
		for (int k = 0; k < 2; k++) begin
			u_cpu.strobe(k[1:0]);
			wait_mode(MODE_LPSLEEP, "lp sleep");
			chk("lp sleep regs", 32'h1, {30'h0, pwr.main_reg, pwr.lp_reg});
			@(posedge clk);
			if (k == 0) irq <= 1'b1;
			else evt <= 1'b1;
			wait_mode(MODE_LPRUN, "lp sleep wake");
			@(posedge clk);
			irq <= 1'b0;
			evt <= 1'b0;
		end
		ahb(1'b1, ADDR_CTRL, 32'h00000000, q);
		wait_mode(MODE_RUN, "lp run exit");
		chk("run regs", 32'h3, {30'h0, pwr.main_reg, pwr.lp_reg});
		$display("test lp run done");

		ahb(1'b1, ADDR_CLK, 32'h000000A0, q);
		for (int l = 0; l < 3; l++) begin
			ahb(1'b1, ADDR_CTRL, 32'(8 + l + (l == 1 ? 64 : 0)), q);
			u_cpu.strobe(l[1:0]);
			wait_mode(lpmc_mode_t'(4 + l), "stop entry");
			chk("stop clocks", 32'h0, {30'h0, ck.cpu, ck.multi_speed_osc});
			chk("stop main reg", 32'(l == 0), 32'(pwr.main_reg));
			chk("stop2 keep", 32'h1, 32'(pwr.stop2_keep));
			chk("radio block", 32'(l == 0), 32'(blk));
			u_cpu.radio_sleep(1'b1);
			hold(6);
			chk("radio reg", 32'(l == 0), 32'(pwr.radio_reg));
			u_cpu.radio_sleep(1'b0);
			hold(6);
			chk("radio reg awake", 32'h1, 32'(pwr.radio_reg));
			@(posedge clk);
			fast_req <= 4'h5;
			#1;
			chk("fast req", 32'h15, {27'h0, ck.fast_osc, route});
			@(posedge clk);
			fast_req <= 4'h0;
			#1;
			chk("fast release", 32'h0, {27'h0, ck.fast_osc, route});
			@(posedge clk);
			if (l == 2) pwake <= 1'b1;
			else ev_line <= 1'b1;
			wait_mode(MODE_RUN, "stop wake");
			chk("wake clock", 32'(l == 1 ? SYSCLK_FAST : SYSCLK_MSI), 32'(sysclk));
			chk("msi kept", 32'hA, 32'(msi_range));
			@(posedge clk);
			pwake <= 1'b0;
			ev_line <= 1'b0;
		end
		$display("test stop done");

		for (int s = 0; s < 2; s++) begin
			ahb(1'b1, ADDR_CLK, 32'h000000A1, q);
			ahb(1'b0, ADDR_CLK, 32'h0, q);
			chk("clk readback", 32'h000000A1, q);
			ahb(1'b1, ADDR_CTRL, 32'(11 + 32 * s), q);
			u_cpu.strobe(2'h0);
			wait_mode(MODE_STANDBY, "standby entry");
			chk("standby regs", 32'(s), {30'h0, pwr.main_reg, pwr.lp_reg});
			chk("sram2 keep", 32'(2 * s), {30'h0, pwr.sram2_keep, pwr.stop2_keep});
			chk("standby clocks", 32'h0, {29'h0, ck.cpu, ck.fast_osc, ck.multi_speed_osc});
			@(posedge clk);
			awake <= (s == 0) ? 8'h01 : 8'h80;
			wait_mode(MODE_RUN, "standby wake");
			chk("restart clock", {SYSCLK_MSI, MSI_RANGE_4MHZ}, {sysclk, msi_range});
			@(posedge clk);
			awake <= 8'h00;
		end
		chk("no discard", 32'h0, 32'(discards));
		$display("test standby done");

		ahb(1'b1, ADDR_CLK, 32'h000000A1, q);
		ahb(1'b1, ADDR_CTRL, 32'h0000000C, q);
		u_cpu.strobe(2'h1);
		wait_mode(MODE_SHUTDOWN, "shutdown entry");
		chk("shutdown regs", 32'h0, {30'h0, pwr.main_reg, pwr.lp_reg});
		chk("shutdown clocks", 32'h1, {28'h0, ck.fast_osc, ck.multi_speed_osc, ck.slow_int, ck.slow_xtal});
		chk("radio forced", 32'h3, {30'h0, frc, r_deep});
		chk("pulls held", 32'h1, 32'(io.pull_hold));
		@(posedge clk);
		awake <= 8'h81;
		hold(8);
		chk("foreign wake", 32'(MODE_SHUTDOWN), 32'(mode));
		@(posedge clk);
		awake <= 8'h10;
		wait_mode(MODE_RUN, "shutdown wake");
		chk("restart clock", {SYSCLK_MSI, MSI_RANGE_4MHZ}, {sysclk, msi_range});
		hold(2);
		chk("pulls dropped", 32'h1, 32'(discards));
		$display("test shutdown done");
		close_out();
	end
endmodule
